// ===== src/optical_port_defines.svh
// timing and field constants for the optical port pin conditioner
`ifndef OPTICAL_PORT_DEFINES_SVH
`define OPTICAL_PORT_DEFINES_SVH

// register offsets (word index)
`define OPT_REG_CTRL 8'h00
`define OPT_REG_STATUS 8'h01

// control field positions
`define OPT_CTRL_TXSEL_LSB 0
`define OPT_CTRL_TXSEL_MSB 1
`define OPT_CTRL_TXINV_BIT 2
`define OPT_CTRL_RXINV_BIT 3
`define OPT_CTRL_MOD_BIT 4
`define OPT_CTRL_DUTY_LSB 5
`define OPT_CTRL_DUTY_MSB 6

// control reset value: pin selected, no inversion, no carrier
`define OPT_CTRL_RESET 8'h00

// pin select code that makes the transmit pin a serial output
`define OPT_TXSEL_SERIAL 2'h0

// carrier timing
`define OPT_CLK_HZ 125000000
`define OPT_CARRIER_HZ 38000
// one carrier period in cycles, rounded down
`define OPT_CARRIER_CYC (`OPT_CLK_HZ / `OPT_CARRIER_HZ)

`endif

// ===== src/optical_port_pkg.sv
// types for the optical port pin conditioner
package optical_port_pkg;

	// carrier duty select codes
	typedef enum logic [1:0] {
		duty_50_type_v = 2'h0,
		duty_25_type_v = 2'h1,
		duty_12_type_v = 2'h2,
		duty_6_type_v = 2'h3
	} duty_sel_type;

endpackage : optical_port_pkg

// ===== src/carrier_gen.sv
// carrier generator: period counter and low-phase comparator
`timescale 1ns/1ps
`include "optical_port_defines.svh"

module carrier_gen #(
	parameter int unsigned PERIOD_CYC = `OPT_CARRIER_CYC
) (
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_rst_b,
	// control
	input wire logic i_run,
	input wire logic [1:0] i_duty,
	// carrier level, low during the duty fraction
	output logic o_carrier
);

	localparam int unsigned CW = $clog2(PERIOD_CYC);

	// period counter
	logic [CW-1:0] cnt_ff;
	logic [CW-1:0] nxt_cnt;
	logic carrier_ff;
	logic [CW-1:0] low_len;
	logic wrap;

	// low length = period >> (duty+1): 50, 25, 12.5, 6.25 percent
	// the shift amount is widened to three bits so code 11 does not wrap
	// code order mapping
	assign low_len = CW'(PERIOD_CYC >> ({1'b0, i_duty} + 3'h1));
	assign wrap = (cnt_ff == CW'(PERIOD_CYC - 1));
	assign nxt_cnt = (!i_run || wrap) ? '0 : cnt_ff + CW'(1);

	// counter and carrier register; idle keeps carrier high
	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			cnt_ff <= '0;
			carrier_ff <= 1'b1;
		end else begin
			cnt_ff <= nxt_cnt;
			carrier_ff <= !(i_run && (nxt_cnt < low_len));
		end
	end

	assign o_carrier = carrier_ff;

	chk_carrier_low_len: assert property (@(posedge i_core_clk)
		disable iff (!i_rst_b)
		(i_run && cnt_ff == '0 && $past(i_run)) |-> !carrier_ff)
		else $error("carrier not low at period start");

endmodule : carrier_gen

// ===== src/optical_port_pin_conditioner.sv
// optical port pin conditioner: polarity, pin select, carrier modulation
`timescale 1ns/1ps
`include "optical_port_defines.svh"

// Functional notes
// - transmit pin drives only when select 00
// - independent tx and rx polarity inversion
// - carrier modulates tx when enabled, powered
// - no carrier in battery backup state
// - duty field picks four duty cycles
// - duty is low fraction of period
module optical_port_pin_conditioner #(
	parameter int unsigned PERIOD_CYC = `OPT_CARRIER_CYC
) (
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_rst_b,
	// register port
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [7:0] o_rdata,
	// power state: high while on battery backup
	input wire logic i_batt_backup,
	// serial core side
	input wire logic i_serial_txd,
	output logic o_serial_rxd,
	// pins
	output logic o_optical_tx_pin,
	output logic o_optical_tx_pin_oe,
	input wire logic i_optical_rx_pin
);

	////////////////////////////////////////////////////////////////
	// registers
	logic [7:0] ctrl_ff; // control register
	logic [7:0] rdata_ff; // read data, valid one cycle after strobe
	logic [7:0] nxt_rdata;
	logic rx_meta_ff; // first synchroniser stage
	logic rx_sync_ff; // second synchroniser stage
	logic batt_meta_ff;
	logic batt_sync_ff;
	logic rxd_ff;
	logic tx_ff;
	logic tx_oe_ff;

	// control fields
	logic [1:0] tx_pin_select;
	logic tx_polarity_invert;
	logic rx_polarity_invert;
	logic tx_carrier_enable;
	logic [1:0] carrier_duty_select;
	logic mod_run;
	logic carrier;
	logic tx_level;
	logic nxt_tx;
	logic sel_ctrl;
	logic sel_status;

	assign tx_pin_select =
		ctrl_ff[`OPT_CTRL_TXSEL_MSB:`OPT_CTRL_TXSEL_LSB];
	assign tx_polarity_invert = ctrl_ff[`OPT_CTRL_TXINV_BIT];
	assign rx_polarity_invert = ctrl_ff[`OPT_CTRL_RXINV_BIT];
	assign tx_carrier_enable = ctrl_ff[`OPT_CTRL_MOD_BIT];
	assign carrier_duty_select =
		ctrl_ff[`OPT_CTRL_DUTY_MSB:`OPT_CTRL_DUTY_LSB];

	////////////////////////////////////////////////////////////////
	// register decode
	assign sel_ctrl = (i_addr == `OPT_REG_CTRL);
	assign sel_status = (i_addr == `OPT_REG_STATUS);
	// status: power state and synchronised raw rx pin; bits 7:2 unused
	assign nxt_rdata = !i_rd ? 8'h00 :
		sel_ctrl ? {1'b0, ctrl_ff[6:0]} :
		sel_status ? {6'h00, rx_sync_ff, batt_sync_ff} : 8'h00;

	// control write and read data register
	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			ctrl_ff <= `OPT_CTRL_RESET;
			rdata_ff <= 8'h00;
		end else begin
			if (i_wr && sel_ctrl) begin
				ctrl_ff <= {1'b0, i_wdata[6:0]};
			end
			rdata_ff <= nxt_rdata;
		end
	end

	////////////////////////////////////////////////////////////////
	// synchronisers for asynchronous pin and power level
	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			rx_meta_ff <= 1'b1;
			rx_sync_ff <= 1'b1;
			batt_meta_ff <= 1'b0;
			batt_sync_ff <= 1'b0;
		end else begin
			rx_meta_ff <= i_optical_rx_pin;
			rx_sync_ff <= rx_meta_ff;
			batt_meta_ff <= i_batt_backup;
			batt_sync_ff <= batt_meta_ff;
		end
	end

	////////////////////////////////////////////////////////////////
	// carrier: stops while on battery, so the emitter draws no pulses
	// modulation when enabled
	assign mod_run = tx_carrier_enable && !batt_sync_ff;

	carrier_gen #(
		.PERIOD_CYC(PERIOD_CYC)
	) u_carrier (
		.i_core_clk(i_core_clk),
		.i_rst_b(i_rst_b),
		.i_run(mod_run),
		.i_duty(carrier_duty_select),
		.o_carrier(carrier)
	);

	// carrier is gated by a high (idle) tx line; a space sends bursts
	// tx polarity
	assign tx_level = i_serial_txd ^ tx_polarity_invert;
	assign nxt_tx = mod_run ? (tx_level | carrier) : tx_level;

	// pin output registers
	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			tx_ff <= 1'b1;
			tx_oe_ff <= 1'b0;
			rxd_ff <= 1'b1;
		end else begin
			tx_ff <= nxt_tx;
			tx_oe_ff <= (tx_pin_select == `OPT_TXSEL_SERIAL);
			rxd_ff <= rx_sync_ff ^ rx_polarity_invert;
		end
	end

	assign o_optical_tx_pin = tx_ff;
	assign o_optical_tx_pin_oe = tx_oe_ff;
	assign o_serial_rxd = rxd_ff;
	assign o_rdata = rdata_ff;

	////////////////////////////////////////////////////////////////
	// checks
	// the enable register still shows its reset value one edge after release
	chk_tx_pin_enable: assert property (@(posedge i_core_clk)
		disable iff (!i_rst_b)
		$past(i_rst_b) |->
		o_optical_tx_pin_oe == ($past(tx_pin_select) == 2'h0))
		else $error("tx enable does not follow select");

	chk_rx_invert: assert property (@(posedge i_core_clk)
		disable iff (!i_rst_b)
		o_serial_rxd == ($past(rx_sync_ff) ^ $past(rx_polarity_invert)))
		else $error("rx polarity wrong");

	chk_tx_plain: assert property (@(posedge i_core_clk)
		disable iff (!i_rst_b)
		!$past(mod_run) |->
		o_optical_tx_pin == ($past(i_serial_txd) ^ $past(tx_polarity_invert)))
		else $error("tx polarity wrong");

	chk_batt_no_mod: assert property (@(posedge i_core_clk)
		disable iff (!i_rst_b)
		($past(batt_sync_ff) && $past(batt_sync_ff, 2)) |-> carrier)
		else $error("carrier active on battery");

	chk_mod_pulses: assert property (@(posedge i_core_clk)
		disable iff (!i_rst_b)
		(mod_run && tx_level) [*3] |=> o_optical_tx_pin)
		else $error("idle tx line modulated");

	chk_duty_low: assert property (@(posedge i_core_clk)
		disable iff (!i_rst_b)
		($rose(mod_run) && !tx_level) ##1 (mod_run && !tx_level) [*2]
		|-> !o_optical_tx_pin)
		else $error("carrier start not low");

	chk_rdata_zero: assert property (@(posedge i_core_clk)
		disable iff (!i_rst_b)
		!$past(i_rd) |-> o_rdata == 8'h00)
		else $error("read data without strobe");

	chk_ctrl_write: assert property (@(posedge i_core_clk)
		disable iff (!i_rst_b)
		(i_wr && sel_ctrl) |=> carrier_duty_select == $past(i_wdata[6:5]))
		else $error("duty field not written");

	cov_mod_run: cover property (@(posedge i_core_clk) $rose(mod_run));
	cov_batt_block: cover property (@(posedge i_core_clk)
		tx_carrier_enable && batt_sync_ff);
	cov_duty_min: cover property (@(posedge i_core_clk)
		mod_run && carrier_duty_select == optical_port_pkg::duty_6_type_v);
	cov_rx_inv: cover property (@(posedge i_core_clk) rx_polarity_invert);

endmodule : optical_port_pin_conditioner

// ===== tb/optical_partner.sv
// far side model: emitter echoed onto the phototransistor
`timescale 1ns/1ps
module optical_partner (
	// emitter side
	input wire logic i_tx_pin,
	input wire logic i_tx_pin_oe,
	// receiver side
	output logic o_rx_pin
);
	// a released emitter pin lets the receiver pull-up win, so rx reads high
	assign o_rx_pin = i_tx_pin_oe ? i_tx_pin : 1'b1;
endmodule : optical_partner

// ===== tb/optical_port_pin_conditioner_bench.sv
// self-checking bench for the optical port pin conditioner
`timescale 1ns/1ps
module optical_port_pin_conditioner_bench;
	// short carrier period keeps each count window brief
	localparam int unsigned PER = 32;
	logic clk, rst_b, wr, rd, batt, txd, rxd, tx_pin, tx_oe, rx_pin;
	logic [7:0] addr, wdata, rdata;
	int errors, checks_done, n;
	optical_port_pin_conditioner #(.PERIOD_CYC(PER)) u_dut (
		.i_core_clk(clk), .i_rst_b(rst_b), .i_addr(addr), .i_wdata(wdata),
		.i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_batt_backup(batt),
		.i_serial_txd(txd), .o_serial_rxd(rxd), .o_optical_tx_pin(tx_pin),
		.o_optical_tx_pin_oe(tx_oe), .i_optical_rx_pin(rx_pin));
	optical_partner u_far (.i_tx_pin(tx_pin), .i_tx_pin_oe(tx_oe),
		.o_rx_pin(rx_pin));
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	////////////////////////////////////////////////////////////////////////
	// compare and count
	task automatic check(input string what, input logic [7:0] exp,
		input logic [7:0] got);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	// one write cycle, then let the pin pipeline settle
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		repeat (5) @(posedge clk);
	endtask : wr_reg
	// read data stand only in the cycle after the strobe
	task automatic rd_reg(input logic [7:0] a, input logic [7:0] e,
		input string what);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		check(what, e, rdata);
	endtask : rd_reg
	// low cycles over one full carrier period, phase does not matter
	task automatic count_low(output int c);
		c = 0;
		repeat (PER) begin
			@(negedge clk);
			c += (tx_pin === 1'b0);
		end
	endtask : count_low
	task automatic pins(input logic [7:0] e, input string what);
		@(negedge clk);
		check(what, e, {5'h0, rxd, tx_oe, tx_pin});
	endtask : pins
	////////////////////////////////////////////////////////////////////////
	// scenarios
	task automatic t_select;
		rd_reg(8'h00, 8'h00, "ctrl reset");
		rd_reg(8'h05, 8'h00, "unmapped read");
		pins(8'h07, "pins idle");
		for (int s = 1; s < 4; s++) begin
			wr_reg(8'h00, 8'(s));
			pins(8'h05, "pin released");
		end
		wr_reg(8'h05, 8'h1c);
		rd_reg(8'h00, 8'h03, "unmapped write");
		wr_reg(8'h00, 8'h80);
		rd_reg(8'h00, 8'h00, "ctrl bit7");
	endtask : t_select
	task automatic t_polarity;
		@(posedge clk);
		txd <= 1'b0;
		wr_reg(8'h00, 8'h00);
		pins(8'h02, "plain low");
		wr_reg(8'h00, 8'h04);
		pins(8'h07, "tx inverted");
		wr_reg(8'h00, 8'h08);
		pins(8'h06, "rx inverted");
		rd_reg(8'h01, 8'h00, "status");
		wr_reg(8'h00, 8'h09);
		pins(8'h00, "rx inverted released");
	endtask : t_polarity
	task automatic t_carrier;
		@(posedge clk);
		txd <= 1'b0;
		for (int d = 0; d < 4; d++) begin
			wr_reg(8'h00, {1'b0, 2'(d), 5'h10});
			count_low(n);
			check("low count", 8'(PER >> (d + 1)), 8'(n));
		end
	endtask : t_carrier
	task automatic t_battery;
		@(posedge clk);
		batt <= 1'b1;
		wr_reg(8'h00, 8'h10);
		rd_reg(8'h01, 8'h01, "battery status");
		count_low(n);
		check("backup low count", 8'(PER), 8'(n));
		@(posedge clk);
		batt <= 1'b0;
		repeat (5) @(posedge clk);
		count_low(n);
		check("powered low count", 8'(PER / 2), 8'(n));
	endtask : t_battery
	////////////////////////////////////////////////////////////////////////
	task automatic print_verdict;
		$display("errors %0d checks_done %0d", errors, checks_done);
		if (errors == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : print_verdict
	// the whole sequence needs well under a thousand cycles
	initial begin
		#(8 * 20000);
		errors++;
		print_verdict();
	end
	initial begin
		errors = 0;
		checks_done = 0;
		rst_b = 1'b0;
		{wr, rd, batt} = 3'h0;
		txd = 1'b1;
		addr = 8'h00;
		wdata = 8'h00;
		repeat (16) @(posedge clk);
		rst_b <= 1'b1;
		t_select();
		t_polarity();
		t_carrier();
		t_battery();
		print_verdict();
	end
endmodule : optical_port_pin_conditioner_bench
